// ==== src/spe_pkg.sv ====
/*
 * Constants, types and carriers for the serial EEPROM command block.
 * Assumes a 50 MHz core clock and an SPI mode 0 master on the link.
 */
package spe_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int T_PROG_NS = 5000000;
	// Longest time, so rounded down
	localparam int PROG_CYC = T_PROG_NS / CLK_NS;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W_DEF = 13;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 32;

	// ----------------------------------------------------------------
	// Command low bits; upper nibble zero, bit 3 ignored
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_SET_LATCH = 3'h6;
	localparam logic [2:0] OP_CLR_LATCH = 3'h4;
	localparam logic [2:0] OP_STAT_RD = 3'h5;
	localparam logic [2:0] OP_STAT_WR = 3'h1;

	// ----------------------------------------------------------------
	// Status byte layout and values
	// ----------------------------------------------------------------
	localparam int ST_PPE = 7;
	localparam int ST_BPH = 3;
	localparam int ST_BPL = 2;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] STATUS_BUSY = 8'hFF;

	typedef enum logic [2:0] {PH_CMD, PH_ADH, PH_ADL, PH_DAT, PH_IGN} spe_phase_t;
	typedef enum logic [2:0] {
		K_NONE, K_READ, K_WRITE, K_SET_LATCH, K_CLR_LATCH, K_STAT_RD, K_STAT_WR
	} spe_kind_t;
	typedef enum logic [1:0] {P_IDLE, P_COPY, P_WAIT} spe_pstate_t;

	// Link side state, clocked by the serial clock
	typedef struct packed {
		spe_phase_t phase;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] txb;
		spe_kind_t kind;
		logic [15:0] addr;
		logic [4:0] off;
		logic bound;
		logic [7:0] sdata;
		logic [31:0] mask;
		logic [7:0] st_s1;
		logic [7:0] st_s2;
	} spe_link_t;

	// Core side state, clocked by clk
	typedef struct packed {
		spe_pstate_t pst;
		logic [31:0] cnt;
		logic [5:0] idx;
		logic latch;
		logic ppe;
		logic [1:0] bp;
		logic [7:0] stat;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic wp_s1;
		logic wp_s2;
	} spe_core_t;

endpackage

// ==== src/spe_eeprom.sv ====
/*
 * Serial EEPROM slave: command decode, status byte, block protection,
 * page write with timed programming, sequential read.
 * Assumes an SPI mode 0 master: input sampled on rising sck, output
 * changed on falling sck; sck is still while cs_n is high.
 */
`timescale 1ns/1ps
module spe_eeprom #(
	parameter int ADDR_W = spe_pkg::ADDR_W_DEF,
	parameter int PROG_CYCLES = spe_pkg::PROG_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	output logic so,
	output logic so_oe
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 12 || ADDR_W > 13) begin : g_bad_addr
		$error("ADDR_W must be 12 or 13");
	end
	if (PROG_CYCLES < 1) begin : g_bad_prog
		$error("PROG_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Array and page buffer have no reset; unwritten bytes read as unknown
	logic [7:0] mem [0:(1 << ADDR_W) - 1];
	logic [7:0] pbuf [0:spe_pkg::PAGE_BYTES - 1];

	spe_pkg::spe_link_t lq;
	spe_pkg::spe_link_t ln;
	spe_pkg::spe_core_t cq;
	spe_pkg::spe_core_t cn;
	logic started_q;
	logic frame_rstn;
	logic pb_we;
	logic [4:0] pb_idx;
	logic [7:0] pb_dat;
	logic mem_we;
	logic [ADDR_W-1:0] wa;
	// One flip per clocked frame; the core keeps the last one it served
	logic frame_tg_q;
	logic frame_ack_q;
	logic frame_new;

	// Deselect clears the frame and floats the output
	assign frame_rstn = rstn & ~cs_n;

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------

	// First edge of a frame seen
	always_ff @(posedge sck or negedge frame_rstn) begin
		if (!frame_rstn) begin
			started_q <= 1'b0;
		end else if (hold_n) begin
			started_q <= 1'b1;
		end
	end

	// Marks a frame that really carried clock edges. A select pulse with
	// no edges must not replay the previous frame's command at its end.
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			frame_tg_q <= 1'b0;
		end else if (hold_n && !started_q) begin
			frame_tg_q <= ~frame_tg_q;
		end
	end

	// Shift, decode and load outgoing bytes
	always_comb begin
		spe_pkg::spe_link_t b;
		logic [7:0] sh;
		logic [15:0] ri;
		logic [ADDR_W-1:0] na;
		b = lq;
		if (!started_q) begin
			b.phase = spe_pkg::PH_CMD;
			b.bitcnt = 3'h0;
			b.kind = spe_pkg::K_NONE;
		end
		sh = {b.shreg[6:0], si};
		ri = (b.phase == spe_pkg::PH_ADL) ? {b.addr[15:8], sh} : b.addr;
		na = ri[ADDR_W-1:0] + 1'b1;
		pb_we = 1'b0;
		pb_idx = b.off;
		pb_dat = sh;
		ln = b;
		ln.shreg = sh;
		ln.bitcnt = b.bitcnt + 3'h1;
		ln.bound = 1'b0;
		// Status changes between frames, and when programming ends, which can
		// fall inside a frame; a plain 2-stage word crossing, the 8 command edges flush it
		ln.st_s1 = cq.stat;
		ln.st_s2 = lq.st_s1;
		if (b.bitcnt == 3'h7) begin
			case (b.phase)
				spe_pkg::PH_CMD: begin
					ln.phase = spe_pkg::PH_IGN;
					ln.kind = spe_pkg::K_NONE;
					if (sh[7:4] == 4'h0) begin
						case (sh[2:0])
							spe_pkg::OP_STAT_RD: begin
								ln.kind = spe_pkg::K_STAT_RD;
								ln.phase = spe_pkg::PH_DAT;
								ln.txb = lq.st_s2;
							end
							spe_pkg::OP_READ: begin
								ln.kind = spe_pkg::K_READ;
								ln.phase = spe_pkg::PH_ADH;
							end
							spe_pkg::OP_WRITE: begin
								ln.kind = spe_pkg::K_WRITE;
								ln.phase = spe_pkg::PH_ADH;
								ln.mask = 32'h0000_0000;
							end
							spe_pkg::OP_SET_LATCH: begin
								ln.kind = spe_pkg::K_SET_LATCH;
							end
							spe_pkg::OP_CLR_LATCH: begin
								ln.kind = spe_pkg::K_CLR_LATCH;
							end
							spe_pkg::OP_STAT_WR: begin
								ln.kind = spe_pkg::K_STAT_WR;
								ln.phase = spe_pkg::PH_DAT;
							end
							default: begin
								ln.kind = spe_pkg::K_NONE;
							end
						endcase
						// Busy status reads all ones; refuse all but status read
						if (lq.st_s2[0] && sh[2:0] != spe_pkg::OP_STAT_RD) begin
							ln.kind = spe_pkg::K_NONE;
							ln.phase = spe_pkg::PH_IGN;
							ln.mask = b.mask;
						end
					end
				end
				spe_pkg::PH_ADH: begin
					ln.addr[15:8] = sh;
					ln.phase = spe_pkg::PH_ADL;
				end
				spe_pkg::PH_ADL: begin
					ln.addr = {b.addr[15:8], sh};
					ln.off = sh[4:0];
					ln.phase = spe_pkg::PH_DAT;
					if (b.kind == spe_pkg::K_READ) begin
						ln.txb = mem[ri[ADDR_W-1:0]];
						ln.addr = 16'(na);
					end
				end
				spe_pkg::PH_DAT: begin
					case (b.kind)
						spe_pkg::K_READ: begin
							// Input no longer sampled here
							ln.txb = mem[ri[ADDR_W-1:0]];
							ln.addr = 16'(na);
						end
						spe_pkg::K_STAT_RD: begin
							ln.txb = lq.st_s2;
						end
						spe_pkg::K_WRITE: begin
							pb_we = 1'b1;
							ln.mask[b.off] = 1'b1;
							ln.off = b.off + 5'h01;
							ln.bound = 1'b1;
						end
						spe_pkg::K_STAT_WR: begin
							ln.sdata = sh;
							ln.bound = 1'b1;
						end
						default: begin
							ln.bound = 1'b0;
						end
					endcase
				end
				default: begin
					ln.phase = spe_pkg::PH_IGN;
				end
			endcase
		end
		// Hold freezes everything, sync stages included
		if (!hold_n) begin
			ln = lq;
			pb_we = 1'b0;
		end
	end

	// Link state register
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			lq <= '{phase: spe_pkg::PH_IGN, kind: spe_pkg::K_NONE, default: '0};
		end else begin
			lq <= ln;
		end
	end

	// Page buffer, filled only by accepted write commands
	always_ff @(posedge sck) begin
		if (pb_we) begin
			pbuf[pb_idx] <= pb_dat;
		end
	end

	// Output changes on the falling edge, MSB first
	// A select rise clears it at once, so the pin floats with no clock
	always_ff @(negedge sck or negedge frame_rstn) begin
		if (!frame_rstn) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (hold_n) begin
			so_oe <= (lq.phase == spe_pkg::PH_DAT) &&
				(lq.kind == spe_pkg::K_READ || lq.kind == spe_pkg::K_STAT_RD);
			so <= lq.txb[~lq.bitcnt];
		end
	end

	// ----------------------------------------------------------------
	// Core domain
	// ----------------------------------------------------------------

	// Protected region for the current code
	// The top address bits pick quarter and half, so both sizes share it
	function automatic logic is_prot(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
		case (bp)
			2'b01: return a[ADDR_W-1 -: 2] == 2'b11;
			2'b10: return a[ADDR_W-1];
			2'b11: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Select rise of a frame not yet served; the toggle is read only here,
	// two clocks after the rise, when the link clock has long been still
	assign frame_new = cq.cs_s2 & ~cq.cs_s3 & (frame_tg_q ^ frame_ack_q);

	// Served frames are acknowledged whether or not they start a cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frame_ack_q <= 1'b0;
		end else if (frame_new) begin
			frame_ack_q <= frame_tg_q;
		end
	end

	// Frame-end decisions and the programming sequence
	always_comb begin
		logic cs_rise;
		cn = cq;
		cn.cs_s1 = cs_n;
		cn.cs_s2 = cq.cs_s1;
		cn.cs_s3 = cq.cs_s2;
		cn.wp_s1 = wp_n;
		cn.wp_s2 = cq.wp_s1;
		cs_rise = cq.cs_s2 & ~cq.cs_s3;
		wa = {lq.addr[ADDR_W-1:spe_pkg::PAGE_W], cq.idx[4:0]};
		mem_we = 1'b0;
		case (cq.pst)
			spe_pkg::P_IDLE: begin
				// Link fields are stable while the link clock is still
				if (cs_rise && frame_new) begin
					case (lq.kind)
						spe_pkg::K_SET_LATCH: cn.latch = 1'b1;
						spe_pkg::K_CLR_LATCH: cn.latch = 1'b0;
						spe_pkg::K_WRITE: begin
							if (cq.latch && lq.bound) begin
								cn.pst = spe_pkg::P_COPY;
								cn.idx = 6'h00;
							end
						end
						spe_pkg::K_STAT_WR: begin
							if (cq.latch && lq.bound && !(cq.ppe && !cq.wp_s2)) begin
								cn.ppe = lq.sdata[spe_pkg::ST_PPE];
								cn.bp = {lq.sdata[spe_pkg::ST_BPH], lq.sdata[spe_pkg::ST_BPL]};
								cn.pst = spe_pkg::P_WAIT;
								cn.cnt = 32'h0000_0000;
							end
						end
						default: cn.pst = spe_pkg::P_IDLE;
					endcase
				end
			end
			spe_pkg::P_COPY: begin
				// Frames during the copy cannot touch mask, address or buffer:
				// busy refuses every command but status read
				// Only bytes sent this frame, never protected ones
				mem_we = lq.mask[cq.idx[4:0]] && !is_prot(cq.bp, wa);
				cn.idx = cq.idx + 6'h01;
				if (cq.idx == 6'(spe_pkg::PAGE_BYTES - 1)) begin
					cn.pst = spe_pkg::P_WAIT;
					cn.cnt = 32'h0000_0000;
				end
			end
			spe_pkg::P_WAIT: begin
				cn.cnt = cq.cnt + 32'h0000_0001;
				// Latch drops with the last busy cycle; next write needs a new one
				if (cq.cnt == 32'(PROG_CYCLES - 1)) begin
					cn.pst = spe_pkg::P_IDLE;
					cn.latch = 1'b0;
				end
			end
			default: cn.pst = spe_pkg::P_IDLE;
		endcase
		// Registered so the crossing sees no glitches
		if (cn.pst != spe_pkg::P_IDLE) begin
			cn.stat = spe_pkg::STATUS_BUSY;
		end else begin
			cn.stat = {cn.ppe, 3'b000, cn.bp, cn.latch, 1'b0};
		end
	end

	// Core state register; latch cleared at reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cq <= '{pst: spe_pkg::P_IDLE, stat: spe_pkg::STATUS_RST,
				cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
				wp_s1: 1'b1, wp_s2: 1'b1, default: '0};
		end else begin
			cq <= cn;
		end
	end

	// Array programming from the page buffer
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[wa] <= pbuf[cq.idx[4:0]];
		end
	end

endmodule

// ==== bench/spe_monitor.sv ====
/*
 * Pin checker for the serial eeprom slave.
 * Assumes it is bound to spe_eeprom and that sck is still while cs_n is high.
 */
`timescale 1ns/1ps
module spe_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe
);
	logic [5:0] n_q;
	logic [7:0] op_q;
	logic ok;
	logic rd;
	logic sr;
	// Edge count and command capture; held edges are not counted
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			n_q <= 6'h00;
			op_q <= 8'h00;
		end else if (hold_n && n_q != 6'h3F) begin
			n_q <= n_q + 6'h01;
			if (n_q < 6'h08) op_q <= {op_q[6:0], si};
		end
	end
	// Command class, valid once eight bits are in
	assign ok = n_q >= 6'h08 && op_q[7:4] == 4'h0 && op_q[2:0] != 3'h0 && op_q[2:0] != 3'h7;
	assign rd = ok && op_q[2:0] == spe_pkg::OP_READ;
	assign sr = ok && op_q[2:0] == spe_pkg::OP_STAT_RD;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_oe_deselect: assert property (cs_n |-> !so_oe)
		else $error("so driven while deselected");
	a_bad_cmd_quiet: assert property (n_q >= 6'h08 && !ok |-> !so_oe)
		else $error("so driven after unknown command");
	a_oe_kind: assert property (so_oe |-> rd || sr)
		else $error("so driven for a non-output command");
	a_read_after_addr: assert property (so_oe && rd |-> n_q >= 6'h18)
		else $error("read data before address done");
	a_stat_answers: assert property (sr && n_q >= 6'h09 |-> so_oe)
		else $error("status read not answered");
	a_read_answers: assert property (rd && n_q >= 6'h19 |-> so_oe)
		else $error("read not answered");
	a_so_steady: assert property (sck && $past(sck) && so_oe && $past(so_oe) |-> $stable(so))
		else $error("so moved while sck high");
	a_hold_freeze: assert property (!hold_n && !$past(hold_n) && so_oe |-> $stable(so))
		else $error("so moved during hold");
endmodule
bind spe_eeprom spe_monitor mon_u (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si),
	.hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));

// ==== bench/spe_host.sv ====
/*
 * Mode 0 bus master model driving one framed transfer at a time.
 * Assumes the caller fills tx and reads rx; sck stands still between frames.
 */
`timescale 1ns/1ps
module spe_host (
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic hold_n,
	input wire logic so,
	input wire logic so_oe
);
	logic [7:0] tx [0:39];
	logic [7:0] rx [0:39];
	logic oe_seen;
	logic last;
	// Idle levels
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
		last = 1'b0;
	end
	// One frame of n bytes at 48 ns per bit; pause with two ignored edges before bit h
	// n of 0 gives a bare select pulse with no clock edges
	task automatic xfer(input int n, input int h);
		int i;
		logic b;
		oe_seen = 1'b0;
		cs_n = 1'b0;
		for (i = 0; i < n * 8; i++) begin
			if (i == h) begin
				// Hold moves mid low phase, clear of any clock edge
				#12 hold_n = 1'b0;
				repeat (2) begin
					#12 sck = 1'b1;
					#24 sck = 1'b0;
					#12;
				end
				#12 hold_n = 1'b1;
			end
			si = tx[i / 8][7 - i % 8];
			#24 sck = 1'b1;
			// A floating so reads as the inverse of the last bit
			b = so_oe ? so : ~last;
			last = b;
			oe_seen |= so_oe;
			rx[i / 8][7 - i % 8] = b;
			#24 sck = 1'b0;
		end
		#24 cs_n = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule

// ==== bench/tb.sv ====
/*
 * Self-checking bench for spe_eeprom through its serial pins.
 * Assumes spe_host as master and a short programming time.
 */
`timescale 1ns/1ps
module tb;
	logic clk, rstn, wp_n, sck, cs_n, si, hold_n, so, so_oe;
	logic [7:0] st, first;
	int err_count, checked, cyc;
	spe_eeprom #(.PROG_CYCLES(60)) dut_u (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
		.si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
	spe_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
	always #10 clk = ~clk;
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Frames start just after a core clock edge
	task automatic go(input int n, input int h);
		@(posedge clk);
		#2 host_u.xfer(n, h);
	endtask
	task automatic stat(output logic [7:0] v, input logic [7:0] op = 8'h05);
		host_u.tx[0] = op;
		host_u.tx[1] = 8'hA5;
		go(2, 99);
		v = host_u.rx[1];
	endtask
	// Poll until ready; first poll kept for the busy check
	task automatic settle();
		int k;
		stat(first);
		st = first;
		for (k = 0; k < 20 && st[0] !== 1'b0; k++) stat(st);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] d = 8'h00, input int n = 1);
		host_u.tx[0] = op;
		host_u.tx[1] = d;
		go(n, 99);
		settle();
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v, input int n);
		int i;
		host_u.tx[0] = 8'h02;
		host_u.tx[1] = a[15:8];
		host_u.tx[2] = a[7:0];
		for (i = 0; i < n; i++) host_u.tx[3 + i] = v + 8'(i);
		go(3 + n, 999);
		settle();
	endtask
	task automatic rd(input logic [15:0] a, input int h = 99);
		host_u.tx[0] = 8'h03;
		host_u.tx[1] = a[15:8];
		host_u.tx[2] = a[7:0];
		go(5, h);
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wp_n = 1'b1;
		repeat (8) @(posedge clk);
		#2 rstn = 1'b1;
		repeat (4) @(posedge clk);
		stat(st);
		chk(st, 8'h00);
		cmd(8'h06);
		chk(st, 8'h02);
		cmd(8'h04);
		chk(st, 8'h00);
		cmd(8'h0E);
		chk(st, 8'h02);
		wr(16'h1FE0, 8'h10, 34);
		chk(first, 8'hFF);
		chk(st, 8'h00);
		cmd(8'h06);
		wr(16'h0000, 8'h5A, 1);
		wr(16'h0000, 8'h00, 1);
		rd(16'h1FFF, 28);
		chk(host_u.rx[3], 8'h2F);
		chk(host_u.rx[4], 8'h5A);
		rd(16'h1FE0);
		chk(host_u.rx[3], 8'h30);
		chk(host_u.rx[4], 8'h31);
		cmd(8'h06);
		cmd(8'h01, 8'h8C, 2);
		chk(first, 8'hFF);
		chk(st, 8'h8C);
		@(posedge clk);
		#2 wp_n = 1'b0;
		cmd(8'h06);
		cmd(8'h01, 8'h00, 2);
		chk(st & 8'hFC, 8'h8C);
		host_u.tx[0] = 8'h01;
		host_u.tx[1] = 8'h00;
		go(2, 99);
		@(posedge clk);
		#2 wp_n = 1'b1;
		go(0, 99);
		settle();
		chk(st, 8'h8E);
		@(posedge clk);
		#2 wp_n = 1'b1;
		cmd(8'h06);
		cmd(8'h01, 8'h84, 2);
		stat(st, 8'h0D);
		chk(st, 8'h84);
		cmd(8'h01, 8'h00, 2);
		chk(st, 8'h84);
		@(posedge clk);
		#2 wp_n = 1'b0;
		cmd(8'h06);
		wr(16'h0000, 8'h66, 1);
		cmd(8'h06);
		wr(16'h1FE0, 8'h77, 1);
		rd(16'h0000);
		chk(host_u.rx[3], 8'h66);
		rd(16'h1FE0);
		chk(host_u.rx[3], 8'h30);
		host_u.tx[0] = 8'h12;
		go(2, 99);
		chk({7'h00, host_u.oe_seen}, 8'h00);
		tally_and_finish();
	end
endmodule
